// file: hdl/adc_seq_pkg.sv
// Purpose: shared constants for the conversion sequencer
// Assumes: 32-bit AHB-Lite register bus, 10 MHz system clock
// Notes:   register indices are word indices; byte address is four times the index
package adc_seq_pkg;
   localparam int unsigned SYS_CLK_HZ = 10_000_000;

   // register word indices
   localparam logic [11:0] IDX_CTRL_THIRD  = 12'hfc0;
   localparam logic [11:0] IDX_CTRL_SECOND = 12'hfc1;
   localparam logic [11:0] IDX_CTRL_FIRST  = 12'hfc2;
   localparam logic [11:0] IDX_RESULT_LOW  = 12'hfc3;
   localparam logic [11:0] IDX_RESULT_HIGH = 12'hfc4;
   localparam logic [11:0] IDX_IRQ_STATUS  = 12'hfc5;
   localparam logic [11:0] IDX_IRQ_MASK    = 12'hfc6;

   // field positions
   localparam int unsigned ACQ_LSB  = 3;
   localparam int unsigned ACQ_W    = 3;
   localparam int unsigned CS_LSB   = 0;
   localparam int unsigned CS_W     = 3;
   localparam int unsigned EN_BIT   = 0;
   localparam int unsigned GO_BIT   = 1;
   localparam int unsigned CH_LSB   = 2;
   localparam int unsigned CH_W     = 4;
   localparam int unsigned DONE_BIT = 0;

   // reset values
   localparam logic [7:0] REG_RESET = 8'h00;

   // conversion timing
   localparam int unsigned RES_BITS  = 10;
   localparam logic [4:0]  CONV_TADS = 5'd11;
   localparam logic [9:0]  SAR_START = 10'h200;

   typedef enum logic [2:0] {
      ST_SAMPLE  = 3'b001,
      ST_ACQUIRE = 3'b010,
      ST_CONVERT = 3'b100
   } seq_state_e;

   // oscillator periods per bit period, minus one; rc codes return zero
   function automatic logic [5:0] tad_limit(input logic [2:0] sel);
      case (sel)
         3'b000:  tad_limit = 6'd1;
         3'b100:  tad_limit = 6'd3;
         3'b001:  tad_limit = 6'd7;
         3'b101:  tad_limit = 6'd15;
         3'b010:  tad_limit = 6'd31;
         3'b110:  tad_limit = 6'd63;
         default: tad_limit = 6'd0;
      endcase
   endfunction : tad_limit

   function automatic logic sel_is_rc(input logic [2:0] sel);
      sel_is_rc = (sel[1:0] == 2'b11);
   endfunction : sel_is_rc

   // bit periods of automatic acquisition: two per step of the field
   function automatic logic [4:0] acq_tads(input logic [2:0] field);
      acq_tads = {1'b0, field, 1'b0};
   endfunction : acq_tads
endpackage : adc_seq_pkg

// file: hdl/pin_sync_rise.sv
// Purpose: two-flop synchroniser with rising-edge pulse
// Assumes: input is asynchronous to sys_clk_i
// Notes:   the first flop feeds only the second
`timescale 1ns/1ps
module pin_sync_rise (
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   output logic      level_o,
   output logic      rise_o
);
   logic meta_ff;
   logic sync_ff;
   logic last_ff;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
      end else begin
         meta_ff <= pin_i;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign level_o = sync_ff;
   assign rise_o  = sync_ff & ~last_ff;
endmodule : pin_sync_rise

// file: hdl/tad_divider.sv
// Purpose: bit-period tick generator
// Assumes: rc_tick_i is a synchronised one-cycle pulse
// Notes:   restart_i drops the partial count so the first period is whole, except with rc selects, whose ticks it does not touch
`timescale 1ns/1ps
module tad_divider
   import adc_seq_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   input  wire logic       restart_i,
   input  wire logic [2:0] sel_i,
   input  wire logic       rc_tick_i,
   output logic            tick_o
);
   logic [5:0] cnt_ff;
   logic       osc_hit;

   assign osc_hit = (cnt_ff == tad_limit(sel_i));

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || restart_i || osc_hit) begin // R12
         cnt_ff <= 6'h00;
      end else begin
         cnt_ff <= cnt_ff + 6'h01; // R12
      end
   end

   // not gated by restart: the sequencer's hand-over is itself made from this tick
   assign tick_o = sel_is_rc(sel_i) ? rc_tick_i : osc_hit; // R8 R9 R11
endmodule : tad_divider

// file: hdl/adc_sequencer.sv
// Purpose: acquisition and conversion sequencer of a 10-bit successive-approximation converter
// Assumes: AHB-Lite slave, single word transfers, one clock
// Notes:   reads take one wait state, writes none; go bit is owned by hardware while busy
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// R1: acquisition time is taken from the third control register at every go.
// R2: zero acquisition field makes go stop sampling and convert at once.
// R3: with zero field, software waits the acquisition time itself before go.
// R4: nonzero field keeps sampling for the programmed time, then converts.
// R5: conversion end clears go, sets done flag, resumes sampling.
// R6: no status separates end of acquisition from start of conversion.
// R7: a full conversion lasts eleven bit periods.
// R8: bit period comes from six oscillator dividers or the rc oscillator.
// R9: select 000=2, 100=4, 001=8, 101=16, 010=32 oscillator periods.
// R10: software picks the shortest bit period above about two microseconds.
// R11: select 110 means 64 periods; any code ending 11 means rc oscillator.
// R12: bit period counts oscillator cycles, restarting at conversion or acquisition start.
module adc_sequencer
   import adc_seq_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        rc_osc_i,
   input  wire logic        cmp_i,
   output logic             sample_o,
   output logic             hold_o,
   output logic      [9:0]  dac_code_o,
   output logic      [3:0]  channel_o,
   output logic             irq_o
);
   import adc_seq_pkg::*;

   // bus state
   logic        wr_ff;
   logic        rd_wait_ff;
   logic [11:0] addr_ff;
   logic [31:0] hrdata_ff;
   logic        accept;
   logic        addr_ok;
   logic [11:0] addr_idx;

   // registers
   logic [7:0]  ctrl_third_ff;
   logic [7:0]  ctrl_second_ff;
   logic [7:0]  ctrl_first_ff;
   logic [7:0]  result_low_ff;
   logic [7:0]  result_high_ff;
   logic [7:0]  irq_status_ff;
   logic [7:0]  irq_mask_ff;

   // sequencer state
   seq_state_e  state_ff;
   seq_state_e  nxt_state;
   logic [4:0]  tad_cnt_ff;
   logic [4:0]  acq_len_ff;
   logic [9:0]  sar_ff;
   logic        tick;
   logic        rc_tick;
   logic        cmp_level;
   logic        start_go;
   logic        restart;
   logic        acq_end;
   logic        conv_end;
   logic        decide;
   logic [3:0]  bit_idx;
   logic [7:0]  wdata;
   logic [2:0]  acq_field;
   logic        busy;
   logic        wr_third;
   logic        wr_second;
   logic        wr_first;
   logic        wr_res_low;
   logic        wr_res_high;
   logic        wr_status;
   logic        wr_mask;
   logic [7:0]  status_set;
   logic [7:0]  status_clr;

   // ---------------- bus slave ----------------
   assign addr_idx = haddr_i[13:2];
   assign accept   = hsel_i & htrans_i[1] & hready_i;
   assign wdata    = hwdata_i[7:0];
   assign addr_ok  = (haddr_i[31:14] == 18'h00000) & (haddr_i[1:0] == 2'b00);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         wr_ff   <= 1'b0;
         addr_ff <= 12'h000;
      end else begin
         wr_ff   <= accept & hwrite_i;
         // addresses above the register window or misaligned decode to index zero, which no register holds
         addr_ff <= (accept && addr_ok) ? addr_idx : 12'h000;
      end
   end

   // one wait state on reads lets a preceding write land before data is sampled
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rd_wait_ff <= 1'b0;
      end else begin
         rd_wait_ff <= accept & ~hwrite_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (rd_wait_ff) begin
         hrdata_ff <= {24'h000000, read_mux(addr_ff)};
      end
   end

   function automatic logic [7:0] read_mux(input logic [11:0] idx);
      case (idx)
         IDX_CTRL_THIRD:  read_mux = ctrl_third_ff;
         IDX_CTRL_SECOND: read_mux = ctrl_second_ff;
         IDX_CTRL_FIRST:  read_mux = ctrl_first_ff;
         IDX_RESULT_LOW:  read_mux = result_low_ff;
         IDX_RESULT_HIGH: read_mux = result_high_ff;
         IDX_IRQ_STATUS:  read_mux = irq_status_ff;
         IDX_IRQ_MASK:    read_mux = irq_mask_ff;
         default:         read_mux = 8'h00;
      endcase
   endfunction : read_mux

   function automatic logic wr_hit(input logic [11:0] idx);
      wr_hit = wr_ff & (addr_ff == idx);
   endfunction : wr_hit

   assign hrdata_o    = hrdata_ff;
   assign hreadyout_o = ~rd_wait_ff;
   assign hresp_o     = 1'b0;

   // one strobe per register, high in the data phase of a write to it
   assign wr_third    = wr_hit(IDX_CTRL_THIRD);
   assign wr_second   = wr_hit(IDX_CTRL_SECOND);
   assign wr_first    = wr_hit(IDX_CTRL_FIRST);
   assign wr_res_low  = wr_hit(IDX_RESULT_LOW);
   assign wr_res_high = wr_hit(IDX_RESULT_HIGH);
   assign wr_status   = wr_hit(IDX_IRQ_STATUS);
   assign wr_mask     = wr_hit(IDX_IRQ_MASK);

   // ---------------- plain registers ----------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_third_ff <= REG_RESET;
      end else if (wr_third) begin
         ctrl_third_ff <= wdata;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_second_ff <= REG_RESET;
      end else if (wr_second) begin
         ctrl_second_ff <= wdata;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_mask_ff <= REG_RESET;
      end else if (wr_mask) begin
         irq_mask_ff <= wdata;
      end
   end

   // ---------------- first control register and go bit ----------------
   assign acq_field = ctrl_third_ff[ACQ_LSB +: ACQ_W];
   // a go written while busy is dropped, so a second go cannot cut a conversion short
   assign busy      = (state_ff != ST_SAMPLE);
   assign start_go  = wr_first & wdata[GO_BIT] & wdata[EN_BIT] & ~busy;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_first_ff <= REG_RESET;
      end else begin
         if (wr_first) begin
            ctrl_first_ff[7:2]    <= wdata[7:2];
            ctrl_first_ff[EN_BIT] <= wdata[EN_BIT];
         end
         // go is the only busy indication while acquiring or converting
         if (conv_end) begin
            ctrl_first_ff[GO_BIT] <= 1'b0; // R5 R6
         end else if (start_go) begin
            ctrl_first_ff[GO_BIT] <= 1'b1;
         end
      end
   end

   // ---------------- bit-period timing ----------------
   pin_sync_rise u_rc_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .pin_i     (rc_osc_i),
      .level_o   (),
      .rise_o    (rc_tick)
   );

   pin_sync_rise u_cmp_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .pin_i     (cmp_i),
      .level_o   (cmp_level),
      .rise_o    ()
   );

   // restart at go and at the hand-over from acquisition to conversion
   assign restart = start_go | acq_end; // R12

   tad_divider u_tad (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .restart_i (restart),
      .sel_i     (ctrl_third_ff[CS_LSB +: CS_W]),
      .rc_tick_i (rc_tick),
      .tick_o    (tick)
   );

   // ---------------- sequencer ----------------
   assign acq_end  = (state_ff == ST_ACQUIRE) & tick
                     & (tad_cnt_ff == acq_len_ff - 5'd1); // R4
   assign conv_end = (state_ff == ST_CONVERT) & tick
                     & (tad_cnt_ff == CONV_TADS - 5'd1); // R7
   assign decide   = (state_ff == ST_CONVERT) & tick & (tad_cnt_ff != 5'd0);
   assign bit_idx  = 4'd10 - tad_cnt_ff[3:0];

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_SAMPLE: begin
            if (start_go) begin
               if (acq_field == 3'b000) begin
                  nxt_state = ST_CONVERT; // R2
               end else begin
                  nxt_state = ST_ACQUIRE; // R1 R4
               end
            end
         end
         ST_ACQUIRE: begin
            if (acq_end) begin
               nxt_state = ST_CONVERT; // R4
            end
         end
         ST_CONVERT: begin
            if (conv_end) begin
               nxt_state = ST_SAMPLE; // R5
            end
         end
         default: nxt_state = ST_SAMPLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_ff <= ST_SAMPLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // acquisition length is frozen at go; later edits of the field wait for the next go
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         acq_len_ff <= 5'd0;
      end else if (start_go) begin
         acq_len_ff <= acq_tads(acq_field); // R1
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || start_go || acq_end || conv_end) begin
         tad_cnt_ff <= 5'd0;
      end else if (tick && busy) begin
         tad_cnt_ff <= tad_cnt_ff + 5'd1; // R7
      end
   end

   // first bit period holds the sample, the next ten resolve bits 9 down to 0
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sar_ff <= SAR_START;
      end else if (state_ff != ST_CONVERT || conv_end) begin
         // the trial code is back at mid-scale in the first sampling cycle
         sar_ff <= SAR_START; // R5
      // two oscillator periods per bit is below the minimum; the compare then lags a trial
      end else if (decide) begin
         sar_ff[bit_idx] <= cmp_level; // R7
         if (bit_idx != 4'd0) begin
            sar_ff[bit_idx - 4'd1] <= 1'b1;
         end
      end
   end

   // results are left justified; the final bit is folded in as it resolves
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         result_high_ff <= REG_RESET;
         result_low_ff  <= REG_RESET;
      end else if (conv_end) begin
         result_high_ff <= sar_ff[9:2]; // R5
         result_low_ff  <= {sar_ff[1], cmp_level, 6'h00};
      end else begin
         if (wr_res_high) begin
            result_high_ff <= wdata;
         end
         if (wr_res_low) begin
            result_low_ff <= wdata;
         end
      end
   end

   // ---------------- interrupt ----------------
   // a completion in the same cycle as a write-one clear keeps the flag set
   assign status_set = {7'h00, conv_end}; // R5
   assign status_clr = wr_status ? wdata : 8'h00;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_status_ff <= REG_RESET;
      end else begin
         irq_status_ff <= (irq_status_ff & ~status_clr) | status_set;
      end
   end

   assign irq_o = |(irq_status_ff & irq_mask_ff);

   // ---------------- analog side ----------------
   assign sample_o   = (state_ff != ST_CONVERT); // R5 R6
   assign hold_o     = (state_ff == ST_CONVERT);
   assign dac_code_o = sar_ff;
   assign channel_o  = ctrl_first_ff[CH_LSB +: CH_W];
endmodule : adc_sequencer

// file: dv/adc_seq_chk.sv
// Purpose: port-level assertions for the conversion sequencer
// Assumes: one clock, synchronous active-high reset
// Notes:   sees only top-level ports
`timescale 1ns/1ps
module adc_seq_chk
   import adc_seq_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        hsel_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hrdata_o,
   input  wire logic        hreadyout_o,
   input  wire logic        hresp_o,
   input  wire logic        sample_o,
   input  wire logic        hold_o,
   input  wire logic [9:0]  dac_code_o,
   input  wire logic        irq_o
);
   logic [9:0] hold_len_ff;
   logic       req;
   assign req = hsel_i && htrans_i[1] && hready_i;
   // counts conversion length so the shortest one can be bounded
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !hold_o) begin
         hold_len_ff <= 10'h000;
      end else begin
         hold_len_ff <= hold_len_ff + 10'h001;
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   hold_inv_a: assert property (hold_o == !sample_o)
      else $error("hold and sample overlap");
   resp_okay_a: assert property (hresp_o == 1'b0)
      else $error("response not okay");
   read_wait_a: assert property (req && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read wait state wrong");
   write_fast_a: assert property (req && hwrite_i |=> hreadyout_o)
      else $error("write stalled");
   rdata_top_a: assert property (hreadyout_o |-> hrdata_o[31:8] == 24'h000000)
      else $error("read data upper bits set");
   dac_idle_a: assert property (sample_o |-> dac_code_o == SAR_START)
      else $error("trial code moves while sampling");
   conv_len_a: assert property ($fell(hold_o) |-> hold_len_ff >= 10'h016)
      else $error("conversion too short");
   conv_end_a: assert property ($rose(hold_o) |-> ##[22:800] $rose(sample_o))
      else $error("conversion did not end");
   dac_step_a: assert property ($rose(hold_o) |-> ##[1:200] $changed(dac_code_o))
      else $error("trial code never stepped");
   cover property (req && !hwrite_i);
   cover property ($fell(hold_o));
   cover property ($rose(irq_o));
endmodule : adc_seq_chk

bind adc_sequencer adc_seq_chk chk_u (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sample_o(sample_o),
   .hold_o(hold_o), .dac_code_o(dac_code_o), .irq_o(irq_o)
);

// file: dv/adc_analog_model.sv
// Purpose: sampler, comparator and rc oscillator beside the sequencer
// Assumes: ideal comparator, rc period of four system clocks
// Notes:   output is noise outside a conversion
`timescale 1ns/1ps
module adc_analog_model (
   input  wire logic       sys_clk_i,
   input  wire logic       hold_i,
   input  wire logic [9:0] dac_code_i,
   input  wire logic [9:0] vin_i,
   output logic            cmp_o,
   output logic            rc_osc_o
);
   logic junk_ff;
   initial begin
      rc_osc_o = 1'b0;
      forever #200 rc_osc_o = ~rc_osc_o;
   end
   initial junk_ff = 1'b0;
   always @(posedge sys_clk_i) junk_ff <= ~junk_ff;
   // a compare outside hold means nothing, so never offer a steady level
   assign cmp_o = hold_i ? (vin_i >= dac_code_i) : junk_ff;
endmodule : adc_analog_model

// file: dv/tb_adc_acquisition_conversion_sequencer.sv
// Purpose: self-checking bench of the conversion sequencer
// Assumes: 10 MHz clock, single word bus transfers
// Notes:   rc oscillator runs at a quarter of the clock
`timescale 1ns/1ps
module tb_adc_acquisition_conversion_sequencer;
   import adc_seq_pkg::*;
   logic        clk, rst, hsel, hwrite, rdy, resp, rc, cmp, smp, hld, irq;
   logic [31:0] haddr, hwdata, rdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [9:0]  dac, vin;
   logic [3:0]  chan;
   int          n_errors, cmp_count;
   localparam logic [2:0] SEL_T [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
   localparam int         TAD_T [8] = '{2, 4, 8, 16, 32, 64, 4, 4};
   localparam logic [9:0] VIN_T [8] = '{10'h3ff, 10'h000, 10'h2d5, 10'h12a,
                                        10'h200, 10'h1ff, 10'h0f0, 10'h301};
   adc_sequencer dut_u (
      .sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(rdy),
      .hrdata_o(rdata), .hreadyout_o(rdy), .hresp_o(resp), .rc_osc_i(rc), .cmp_i(cmp),
      .sample_o(smp), .hold_o(hld), .dac_code_o(dac), .channel_o(chan), .irq_o(irq)
   );
   adc_analog_model ana_u (
      .sys_clk_i(clk), .hold_i(hld), .dac_code_i(dac), .vin_i(vin),
      .cmp_o(cmp), .rc_osc_o(rc)
   );
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // entered and left just after a rising edge
   task xfer(input logic w, input logic [11:0] idx, input logic [7:0] d,
             output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {18'h00000, idx, 2'h0};
      @(posedge clk);
      while (!rdy) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      @(posedge clk);
      while (!rdy) @(posedge clk);
      r = rdata;
   endtask : xfer
   task wr(input logic [11:0] idx, input logic [7:0] d);
      logic [31:0] r;
      xfer(1'b1, idx, d, r);
   endtask : wr
   task rd_chk(input string nm, input logic [11:0] idx, input logic [7:0] e);
      logic [31:0] r;
      xfer(1'b0, idx, 8'h00, r);
      chk(nm, r, {24'h000000, e});
   endtask : rd_chk
   task t_reset;
      chk("sample", smp, 1'b1);
      chk("dac", dac, SAR_START);
      for (int k = 0; k < 7; k++) rd_chk("reset", IDX_CTRL_THIRD + k[11:0], REG_RESET);
      wr(IDX_CTRL_SECOND, 8'ha5);
      rd_chk("second", IDX_CTRL_SECOND, 8'ha5);
      wr(12'h010, 8'h5a);
      rd_chk("unmapped", 12'h010, 8'h00);
      wr(IDX_CTRL_FIRST, 8'h3c);
      @(posedge clk);
      chk("channel", chan, 4'hf);
      wr(IDX_CTRL_FIRST, 8'h00);
   endtask : t_reset
   task t_conv(input logic [2:0] f, input logic [2:0] s, input int tad, input logic [9:0] v);
      int a, h, th, ta, ea;
      a = 0;
      h = 0;
      th = (s[1:0] == 2'h3) ? 4 : 0;
      ta = (s[1:0] == 2'h3) ? 6 : 2;
      ea = 2 * f * tad;
      vin <= v;
      wr(IDX_CTRL_THIRD, {2'h0, f, s});
      if (f == 3'h0) repeat (20) @(posedge clk);
      wr(IDX_CTRL_FIRST, 8'h03);
      @(negedge clk);
      while (smp) begin
         a++;
         @(negedge clk);
      end
      while (hld) begin
         h++;
         @(negedge clk);
      end
      @(posedge clk);
      chk("hold", h >= 11 * tad - th && h <= 11 * tad + th, 1'b1);
      chk("acq", f == 3'h0 ? a == 0 : a + ta >= ea && a <= ea + ta, 1'b1);
      rd_chk("go", IDX_CTRL_FIRST, 8'h01);
      rd_chk("high", IDX_RESULT_HIGH, v[9:2]);
      rd_chk("low", IDX_RESULT_LOW, {v[1:0], 6'h00});
      rd_chk("done", IDX_IRQ_STATUS, 8'h01);
      chk("masked", irq, 1'b0);
      wr(IDX_IRQ_STATUS, 8'h01);
      rd_chk("cleared", IDX_IRQ_STATUS, 8'h00);
   endtask : t_conv
   task t_irq;
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_CTRL_THIRD, 8'h02);
      wr(IDX_CTRL_FIRST, 8'h03);
      @(negedge clk);
      while (hld) @(negedge clk);
      chk("irq", irq, 1'b1);
      @(posedge clk);
      wr(IDX_IRQ_MASK, 8'h00);
      @(posedge clk);
      chk("irq off", irq, 1'b0);
      wr(IDX_IRQ_MASK, 8'h01);
      @(posedge clk);
      chk("irq on", irq, 1'b1);
      wr(IDX_IRQ_STATUS, 8'h01);
      @(posedge clk);
      chk("irq clr", irq, 1'b0);
   endtask : t_irq
   task give_verdict;
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      give_verdict;
   end
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      vin = 10'h000;
      n_errors = 0;
      cmp_count = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      // every select code once, acquisition field stepping with it
      for (int i = 0; i < 8; i++) t_conv(i[2:0], SEL_T[i], TAD_T[i], VIN_T[i]);
      t_irq;
      give_verdict;
   end
endmodule : tb_adc_acquisition_conversion_sequencer
